// >>> rtl/ilsup_regs.vh
// register map, field positions, opcodes and timing counts of the interlock supervisor
// assumes: included by the supervisor design files and the bench, by bare name
`ifndef ILSUP_REGS_VH
`define ILSUP_REGS_VH

// =====================================================================
// register offsets (byte addresses, one 32-bit word each)
`define ILSUP_SEL         8'h00
`define ILSUP_CFG         8'h04
`define ILSUP_TIME        8'h08
`define ILSUP_EXPR0       8'h0C
`define ILSUP_EXPR1       8'h10
`define ILSUP_CMD         8'h14
`define ILSUP_STATUS      8'h18
`define ILSUP_STATE       8'h1C

// =====================================================================
// sizes
`define ILSUP_NCOMB       7'h64
`define ILSUP_LAST_IDX    7'h63
`define ILSUP_NUM_MIN     7'h01
`define ILSUP_NUM_MAX     7'h63
`define ILSUP_TMO_MIN     8'h05

// =====================================================================
// configuration word fields
`define ILSUP_CFG_AREA_LSB   0
`define ILSUP_CFG_POINT_LSB  8
`define ILSUP_CFG_HAS_OUT    16
`define ILSUP_CFG_HAS_IN     17
`define ILSUP_CFG_LATCH      18
`define ILSUP_CFG_BUZZ       19
`define ILSUP_CFG_FAULT_EN   20
`define ILSUP_CFG_DELAYED    21
`define ILSUP_CFG_RESET      22'h00_0000

// time word: activation delay [7:0] and feedback timeout [15:8], both in seconds
`define ILSUP_TIME_TMO_LSB   8
`define ILSUP_TIME_RESET     16'h0505

// expression term: three literal selects, use mask, invert mask, term negation
`define ILSUP_TERM_USE_LSB   15
`define ILSUP_TERM_INV_LSB   18
`define ILSUP_TERM_NEG       21

// =====================================================================
// command opcodes in CMD[18:16]; area in [6:0], point in [14:8]
`define ILSUP_OP_ACT      3'h1
`define ILSUP_OP_RESET    3'h2
`define ILSUP_OP_DIS      3'h3
`define ILSUP_OP_EN       3'h4
`define ILSUP_OP_CDIS     3'h5
`define ILSUP_OP_CEN      3'h6
`define ILSUP_OP_SIL      3'h7

// audible source codes, highest priority first
`define ILSUP_TONE_FIRE   2'h3
`define ILSUP_TONE_PREW   2'h2
`define ILSUP_TONE_ILK    2'h1
`define ILSUP_TONE_FAULT  2'h0

// =====================================================================
// timing
`define ILSUP_CLK_HZ      32'h0BEB_C200
`define ILSUP_TICK_S      32'h0000_0001
`define ILSUP_BUZ_MS      32'h0000_0320
`define ILSUP_MS_PER_S    32'h0000_03E8
`define ILSUP_TICK_CYC    (`ILSUP_CLK_HZ * `ILSUP_TICK_S)
`define ILSUP_BUZ_CYC     (`ILSUP_CLK_HZ / `ILSUP_MS_PER_S * `ILSUP_BUZ_MS)

`endif

// >>> rtl/ilsup_expr.v
// control expression evaluator: two OR-ed terms, each an optionally negated AND of literals
// assumes: trigger vector already synchronised to the supervisor clock
`timescale 1ns/1ps
`include "ilsup_regs.vh"

module ilsup_expr (
  input  wire [31:0] trig,
  input  wire [21:0] term0,
  input  wire [21:0] term1,
  output wire        y
);

  // =====================================================================
  // one term; an empty use mask makes the term false
  function term_val;
    input [31:0] tv;
    input [21:0] t;
    reg   [2:0]  lit;
    reg   [2:0]  use_m;
    reg   [2:0]  inv_m;
    reg          conj;
    begin
      use_m = t[`ILSUP_TERM_USE_LSB +: 3];
      inv_m = t[`ILSUP_TERM_INV_LSB +: 3];
      lit[0] = tv[t[4:0]] ^ inv_m[0];
      lit[1] = tv[t[9:5]] ^ inv_m[1];
      lit[2] = tv[t[14:10]] ^ inv_m[2];
      conj = &(lit | ~use_m);
      // negation of the whole conjunction acts as NOT ( ... )
      term_val = (|use_m) & (conj ^ t[`ILSUP_TERM_NEG]);
    end
  endfunction

  // terms are formed before the OR, so AND binds tighter
  assign y = term_val(trig, term0) | term_val(trig, term1);

endmodule

// >>> rtl/ilsup_buzz.v
// panel buzzer: audible priority and interlocking on/off cadence
// assumes: request and silence are single-cycle pulses on the same clock
`timescale 1ns/1ps
`include "ilsup_regs.vh"

module ilsup_buzz #(
  parameter [31:0] HALF_CYC = `ILSUP_BUZ_CYC
) (
  input  wire       ref_clk,
  input  wire       rst_b,
  input  wire       ce,
  input  wire       ilk_req,
  input  wire       silence,
  input  wire       fire_alarm,
  input  wire       pre_warn,
  input  wire       fault_any,
  output reg        buzzer,
  output reg  [1:0] tone
);

  reg        ilk_on;
  reg        phase;
  reg [31:0] cnt;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ilk_on <= 1'b0;
      phase  <= 1'b0;
      cnt    <= 32'h0000_0000;
      buzzer <= 1'b0;
      tone   <= `ILSUP_TONE_FAULT;
    end else if (ce) begin
      // a fresh feedback activation restarts even a silenced buzzer
      if (ilk_req) begin
        ilk_on <= 1'b1;
      end else if (silence) begin
        ilk_on <= 1'b0;
      end
      if (ilk_req && !ilk_on) begin
        phase <= 1'b1;
        cnt   <= 32'h0000_0000;
      end else if (cnt + 32'h0000_0001 >= HALF_CYC) begin
        phase <= ~phase;
        cnt   <= 32'h0000_0000;
      end else begin
        cnt <= cnt + 32'h0000_0001;
      end
      if (fire_alarm) begin
        buzzer <= 1'b1;
        tone   <= `ILSUP_TONE_FIRE;
      end else if (pre_warn) begin
        buzzer <= 1'b1;
        tone   <= `ILSUP_TONE_PREW;
      end else if (ilk_on) begin
        buzzer <= phase;
        tone   <= `ILSUP_TONE_ILK;
      end else begin
        buzzer <= fault_any;
        tone   <= `ILSUP_TONE_FAULT;
      end
    end
  end

endmodule

// >>> rtl/ilsup_top.v
// interlocking output supervisor with AHB-Lite register slave
// assumes: trig_pin and fb_pin are asynchronous pins; alarm/fault flags come from
// panel logic on ref_clk; one AHB-Lite master, single word transfers
//
// Function
// - AND is true only when every operand is true.
// - OR is true when any operand is true.
// - NOT inverts the single condition it applies to.
// - AND binds tighter than OR without parentheses.
// - parenthesised groups are evaluated first, so NOT of a group differs.
// - precedence: parentheses, NOT, AND, OR.
// - up to 100 combinations, each one output and one feedback input.
// - output-only or input-only combinations still work and show activation.
// - each combination is named by area and point, each 1 to 99.
// - feedback activation sounds buzzer 0.8 s on/off; silenceable, restarts on new input.
// - latched outputs stay on after expression falls until reset command.
// - manual activate turns output on even with expression false.
// - manual outputs are supervised the same and stay on until reset.
// - missing feedback within 5-255 s raises a fault naming area and point.
// - with delayed activation, timeout starts after the delay expires.
// - output is steady or steady after a delay, never pulsed.
// - audible priority: fire, pre-warning, interlocking, fault.
// - summary indication only when no alarm, fault or disablement pending.
// - disabled output stays or returns inactive whatever else happens.
// - outputs disable by area and point, or all collectively.
// - collective re-enable undoes collective; individual undoes individual.
// - any disabled output lights the general disablement indicator.
`timescale 1ns/1ps
`include "ilsup_regs.vh"

module ilsup_top #(
  parameter [31:0] TICK_CYC     = `ILSUP_TICK_CYC,
  parameter [31:0] BUZ_HALF_CYC = `ILSUP_BUZ_CYC
) (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire        ce,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [31:0] trig_pin,
  input  wire [99:0] fb_pin,
  input  wire        fire_alarm,
  input  wire        pre_warn,
  input  wire        fault_any,
  input  wire        disable_any,
  output reg  [99:0] ilk_out,
  output wire        buzzer,
  output wire [1:0]  tone,
  output reg         ind_summary,
  output reg         ind_disable
);

  // =====================================================================
  // helpers
  function num_ok;
    input [6:0] n;
    begin
      num_ok = (n >= `ILSUP_NUM_MIN) && (n <= `ILSUP_NUM_MAX);
    end
  endfunction

  // a bit follows the pin only once stages two and three agree
  function [99:0] sync_upd;
    input [99:0] cur;
    input [99:0] s2;
    input [99:0] s3;
    begin
      sync_upd = (s2 & ~(s2 ^ s3)) | (cur & (s2 ^ s3));
    end
  endfunction

  // =====================================================================
  // storage
  reg [21:0] cfg_m  [0:99];
  reg [15:0] tim_m  [0:99];
  reg [21:0] ex0_m  [0:99];
  reg [21:0] ex1_m  [0:99];
  reg [7:0]  tmr_m  [0:99];
  reg [99:0] act;
  reg [99:0] man;
  reg [99:0] dd;
  reg [99:0] flt;
  reg [99:0] fbseen;
  reg [99:0] fbp;
  reg [99:0] ind_dis;

  reg [31:0] trig_s1, trig_s2, trig_s3, trig_f;
  reg [99:0] fb_s1, fb_s2, fb_s3, fb_f;

  reg        dph;
  reg        w_reg;
  reg [7:0]  a_reg;
  reg [6:0]  sel;
  reg        cfg_err;
  reg        coll_dis;
  reg        cmd_pend;
  reg        cmd_run;
  reg [2:0]  cmd_op;
  reg [6:0]  cmd_area;
  reg [6:0]  cmd_point;
  reg        flt_pend;
  reg [6:0]  flt_area;
  reg [6:0]  flt_point;
  reg [6:0]  idx;
  reg [31:0] tick_cnt;
  reg        tick_pend;
  reg        rnd;
  reg        acc_act, acc_dis, any_act, any_dis;
  reg        buz_req;
  reg        sil;

  // =====================================================================
  // one combination per cycle, swept 0..99
  wire [21:0] cc  = cfg_m[idx];
  wire [15:0] tt  = tim_m[idx];
  wire        ex_y;

  ilsup_expr u_expr (
    .trig  (trig_f),
    .term0 (ex0_m[idx]),
    .term1 (ex1_m[idx]),
    .y     (ex_y)
  );

  reg       hit;
  reg       next_dis, next_act, next_man, next_dd, next_flt, next_seen, raise;
  reg [7:0] next_tmr;
  reg       fb_now, drive;

  always @* begin
    hit = cmd_run && cc[6:0] == cmd_area && cc[14:8] == cmd_point
          && (cc[`ILSUP_CFG_HAS_OUT] || cc[`ILSUP_CFG_HAS_IN]);
    next_dis = ind_dis[idx];
    if (hit && cmd_op == `ILSUP_OP_DIS) next_dis = 1'b1;
    if (hit && cmd_op == `ILSUP_OP_EN)  next_dis = 1'b0;
    next_act = act[idx];
    next_man = man[idx];
    if (next_dis || coll_dis) begin
      next_act = 1'b0;
      next_man = 1'b0;
    end else if (hit && cmd_op == `ILSUP_OP_RESET) begin
      next_act = 1'b0;
      next_man = 1'b0;
    end else if (hit && cmd_op == `ILSUP_OP_ACT && cc[`ILSUP_CFG_HAS_OUT]) begin
      next_act = 1'b1;
      next_man = 1'b1;
    end else if (ex_y && cc[`ILSUP_CFG_HAS_OUT]) begin
      next_act = 1'b1;
    end else if (!man[idx] && !cc[`ILSUP_CFG_LATCH]) begin
      next_act = 1'b0;
    end
    fb_now    = fb_f[idx] && cc[`ILSUP_CFG_HAS_IN];
    next_dd   = dd[idx];
    next_tmr  = tmr_m[idx];
    next_flt  = flt[idx];
    next_seen = fbseen[idx] | fb_now;
    raise     = 1'b0;
    if (hit && cmd_op == `ILSUP_OP_RESET) next_flt = 1'b0;
    if (!next_act) begin
      next_dd   = 1'b0;
      next_tmr  = 8'h00;
      next_seen = 1'b0;
    end else if (!act[idx]) begin
      // manual and expression activations enter the same supervision
      next_dd   = !cc[`ILSUP_CFG_DELAYED];
      next_tmr  = 8'h00;
      next_seen = fb_now;
      next_flt  = 1'b0;
    end else if (rnd) begin
      if (!dd[idx]) begin
        if (next_tmr + 8'h01 >= tt[7:0]) begin
          next_dd  = 1'b1;
          next_tmr = 8'h00;
        end else begin
          next_tmr = next_tmr + 8'h01;
        end
      end else if (cc[`ILSUP_CFG_FAULT_EN] && cc[`ILSUP_CFG_HAS_IN]
                   && !next_seen && !flt[idx]) begin
        if (next_tmr + 8'h01 >= tt[15:8]) begin
          next_flt = 1'b1;
          raise    = 1'b1;
        end else begin
          next_tmr = next_tmr + 8'h01;
        end
      end
    end
    drive = next_act && next_dd && cc[`ILSUP_CFG_HAS_OUT];
  end

  // =====================================================================
  // bus read mux
  reg [31:0] rd;
  always @* begin
    case (a_reg)
      `ILSUP_SEL:    rd = {25'h000_0000, sel};
      `ILSUP_CFG:    rd = {10'h000, cfg_m[sel]};
      `ILSUP_TIME:   rd = {16'h0000, tim_m[sel]};
      `ILSUP_EXPR0:  rd = {10'h000, ex0_m[sel]};
      `ILSUP_EXPR1:  rd = {10'h000, ex1_m[sel]};
      `ILSUP_CMD:    rd = {13'h0000, cmd_op, 1'b0, cmd_point, 1'b0, cmd_area};
      `ILSUP_STATUS: rd = {1'b0, flt_point, 1'b0, flt_area, 9'h000, coll_dis,
                           flt_pend, buzzer, cfg_err, cmd_pend | cmd_run,
                           any_dis, any_act};
      `ILSUP_STATE:  rd = {25'h000_0000, fb_f[sel], ind_dis[sel] | coll_dis,
                           flt[sel], dd[sel], man[sel], act[sel], ilk_out[sel & 7'h7F]};
      default:       rd = 32'h0000_0000;
    endcase
  end

  // =====================================================================
  // AHB-Lite: one wait state; the data phase completes on a cycle with ce high
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dph       <= 1'b0;
      w_reg     <= 1'b0;
      a_reg     <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (hready && hsel && htrans[1]) begin
        dph       <= 1'b1;
        w_reg     <= hwrite;
        a_reg     <= haddr[7:0];
        hreadyout <= 1'b0;
      end else if (dph && ce) begin
        dph       <= 1'b0;
        hreadyout <= 1'b1;
        hrdata    <= w_reg ? 32'h0000_0000 : rd;
      end
    end
  end

  wire wr = dph && ce && w_reg;
  wire cmd_ok = wr && a_reg == `ILSUP_CMD && !cmd_pend && !cmd_run;
  wire [2:0] wop = hwdata[18:16];
  wire tick_wrap = tick_cnt + 32'h0000_0001 >= TICK_CYC;
  wire [99:0] trig_upd = sync_upd({68'h0, trig_f}, {68'h0, trig_s2}, {68'h0, trig_s3});

  // =====================================================================
  // block state
  integer i;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < 100; i = i + 1) begin
        cfg_m[i] <= `ILSUP_CFG_RESET;
        tim_m[i] <= `ILSUP_TIME_RESET;
        ex0_m[i] <= 22'h00_0000;
        ex1_m[i] <= 22'h00_0000;
        tmr_m[i] <= 8'h00;
      end
      {act, man, dd, flt, fbseen, fbp, ind_dis, ilk_out} <= 800'h0;
      {trig_s1, trig_s2, trig_s3, trig_f} <= 128'h0;
      {fb_s1, fb_s2, fb_s3, fb_f} <= 400'h0;
      sel <= 7'h00;
      cfg_err <= 1'b0;
      coll_dis <= 1'b0;
      cmd_pend <= 1'b0;
      cmd_run <= 1'b0;
      cmd_op <= 3'h0;
      cmd_area <= 7'h00;
      cmd_point <= 7'h00;
      flt_pend <= 1'b0;
      flt_area <= 7'h00;
      flt_point <= 7'h00;
      idx <= 7'h00;
      tick_cnt <= 32'h0000_0000;
      tick_pend <= 1'b0;
      rnd <= 1'b0;
      {acc_act, acc_dis, any_act, any_dis} <= 4'h0;
      buz_req <= 1'b0;
      sil <= 1'b0;
      ind_summary <= 1'b0;
      ind_disable <= 1'b0;
    end else if (ce) begin
      trig_s1 <= trig_pin;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      trig_f  <= trig_upd[31:0];
      fb_s1   <= fb_pin;
      fb_s2   <= fb_s1;
      fb_s3   <= fb_s2;
      fb_f    <= sync_upd(fb_f, fb_s2, fb_s3);

      // seconds timebase; one tick is consumed by a whole sweep
      tick_cnt <= tick_wrap ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      if (idx == 7'h00) begin
        rnd       <= tick_pend | tick_wrap;
        tick_pend <= 1'b0;
      end else if (tick_wrap) begin
        tick_pend <= 1'b1;
      end

      // register writes
      sil <= cmd_ok && wop == `ILSUP_OP_SIL;
      if (wr && a_reg == `ILSUP_SEL) begin
        if (hwdata[6:0] < `ILSUP_NCOMB) sel <= hwdata[6:0];
      end
      if (wr && a_reg == `ILSUP_CFG) begin
        if (num_ok(hwdata[6:0]) && num_ok(hwdata[14:8]))
          cfg_m[sel] <= hwdata[21:0];
      end
      if (wr && a_reg == `ILSUP_TIME && hwdata[15:8] >= `ILSUP_TMO_MIN)
        tim_m[sel] <= hwdata[15:0];
      if (wr && a_reg == `ILSUP_EXPR0) ex0_m[sel] <= hwdata[21:0];
      if (wr && a_reg == `ILSUP_EXPR1) ex1_m[sel] <= hwdata[21:0];
      if (cmd_ok && wop == `ILSUP_OP_CDIS) coll_dis <= 1'b1;
      if (cmd_ok && wop == `ILSUP_OP_CEN)  coll_dis <= 1'b0;
      if (cmd_ok && (wop == `ILSUP_OP_ACT || wop == `ILSUP_OP_RESET
                     || wop == `ILSUP_OP_DIS || wop == `ILSUP_OP_EN)) begin
        cmd_pend  <= 1'b1;
        cmd_op    <= wop;
        cmd_area  <= hwdata[6:0];
        cmd_point <= hwdata[14:8];
      end else if (idx == `ILSUP_LAST_IDX) begin
        // a run covers one whole sweep, combination 0 included
        cmd_pend <= 1'b0;
        cmd_run  <= cmd_pend;
      end

      // error flags: a hardware set wins over a write-one clear
      if (wr && (a_reg == `ILSUP_CFG) &&
          !(num_ok(hwdata[6:0]) && num_ok(hwdata[14:8])))
        cfg_err <= 1'b1;
      else if (wr && a_reg == `ILSUP_TIME && hwdata[15:8] < `ILSUP_TMO_MIN)
        cfg_err <= 1'b1;
      else if (wr && a_reg == `ILSUP_STATUS && hwdata[3])
        cfg_err <= 1'b0;
      if (raise) begin
        flt_pend  <= 1'b1;
        flt_area  <= cc[6:0];
        flt_point <= cc[14:8];
      end else if (wr && a_reg == `ILSUP_STATUS && hwdata[5]) begin
        flt_pend <= 1'b0;
      end

      // sweep write-back
      act[idx]     <= next_act;
      man[idx]     <= next_man;
      dd[idx]      <= next_dd;
      flt[idx]     <= next_flt;
      fbseen[idx]  <= next_seen;
      fbp[idx]     <= fb_now;
      ind_dis[idx] <= next_dis;
      tmr_m[idx]   <= next_tmr;
      ilk_out[idx] <= drive;
      buz_req      <= fb_now && !fbp[idx] && cc[`ILSUP_CFG_BUZZ];

      // activation is shown for outputs and for input-only feedback alike
      if (idx == `ILSUP_LAST_IDX) begin
        any_act <= acc_act | next_act | fb_now;
        any_dis <= acc_dis | (next_dis & cc[`ILSUP_CFG_HAS_OUT]);
        acc_act <= 1'b0;
        acc_dis <= 1'b0;
        idx     <= 7'h00;
      end else begin
        acc_act <= acc_act | next_act | fb_now;
        acc_dis <= acc_dis | (next_dis & cc[`ILSUP_CFG_HAS_OUT]);
        idx     <= idx + 7'h01;
      end

      ind_disable <= any_dis | coll_dis;
      ind_summary <= any_act && !fire_alarm && !fault_any && !flt_pend
                     && !disable_any && !any_dis && !coll_dis;
    end
  end

  ilsup_buzz #(
    .HALF_CYC (BUZ_HALF_CYC)
  ) u_buzz (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .ce         (ce),
    .ilk_req    (buz_req),
    .silence    (sil),
    .fire_alarm (fire_alarm),
    .pre_warn   (pre_warn),
    .fault_any  (fault_any),
    .buzzer     (buzzer),
    .tone       (tone)
  );

endmodule

// >>> test/ilsup_equip.sv
// controlled equipment model: one feedback contact per supervised output
// assumes: contact i answers output i; a muted contact never closes
`timescale 1ns/1ps
module ilsup_equip (
  input  wire         ref_clk,
  input  wire [99:0]  ilk_out,
  input  wire [99:0]  mute,
  input  wire         slow,
  output wire [99:0]  fb_pin
);
  // =====================================================================
  // contact lag
  reg     [99:0] lag [0:63];
  integer        k;
  integer        n;
  initial begin
    for (n = 0; n < 64; n = n + 1)
      lag[n] = 100'h0;
  end
  // a slow actuator closes its contact only after 64 cycles
  always @(posedge ref_clk) begin
    lag[0] <= ilk_out;
    for (k = 1; k < 64; k = k + 1)
      lag[k] <= lag[k-1];
  end
  // a muted contact stays open, which is how a broken actuator looks
  assign fb_pin = (slow ? lag[63] : lag[2]) & ~mute;
endmodule

// >>> test/ilsup_checker.sv
// port checks for the interlock supervisor
// assumes: bound to ilsup_top; hready is fed from hreadyout
`timescale 1ns/1ps
module ilsup_checker #(
  parameter [31:0] BUZ_HALF_CYC = 32'h0000_0014
) (
  input wire        ref_clk,
  input wire        rst_b,
  input wire        ce,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire        fire_alarm,
  input wire        pre_warn,
  input wire        fault_any,
  input wire        disable_any,
  input wire        buzzer,
  input wire [1:0]  tone,
  input wire        ind_summary,
  input wire        ind_disable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // =====================================================================
  // helper: length of the current cadence phase, on or off
  wire        take = hready && hsel && htrans[1];
  reg  [31:0] run;
  reg         buz_q;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run   <= 32'h0000_0000;
      buz_q <= 1'b0;
    end else begin
      buz_q <= buzzer;
      if (buzzer != buz_q || tone != 2'h1)
        run <= 32'h0000_0000;
      else if (ce)
        run <= run + 32'h0000_0001;
    end
  end
  // =====================================================================
  // assertions
  a_okay_resp: assert property (hresp == 1'b0)
    else $error("bus response not OKAY");
  a_wait_state: assert property (take |=> !hreadyout)
    else $error("no wait state after address phase");
  a_data_done: assert property (take ##1 ce |=> hreadyout)
    else $error("transfer not done after one wait state");
  a_fire_first: assert property ((fire_alarm && ce) [*3] |-> tone == 2'h3 && buzzer)
    else $error("fire alarm does not own the buzzer");
  a_prew_next: assert property ((pre_warn && !fire_alarm && ce) [*3] |-> tone == 2'h2)
    else $error("pre-warning tone missing");
  a_summary_low: assert property (((fire_alarm || fault_any || disable_any) && ce) [*3] |-> !ind_summary)
    else $error("summary shown while alarm or fault pending");
  a_dis_hides: assert property (ind_disable [*3] |-> !ind_summary)
    else $error("summary shown while disablement pending");
  a_cadence_on: assert property (buzzer && tone == 2'h1 |-> run < BUZ_HALF_CYC + 2)
    else $error("interlocking buzzer on-phase too long");
endmodule

bind ilsup_top ilsup_checker #(.BUZ_HALF_CYC(BUZ_HALF_CYC)) u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .hsel(hsel), .htrans(htrans),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .fire_alarm(fire_alarm),
  .pre_warn(pre_warn), .fault_any(fault_any), .disable_any(disable_any),
  .buzzer(buzzer), .tone(tone), .ind_summary(ind_summary), .ind_disable(ind_disable));

// >>> test/tb_top.sv
// self-checking bench for the interlock supervisor
// assumes: tick shortened to 200 cycles, cadence to 20; one bus master
`timescale 1ns/1ps
`include "ilsup_regs.vh"
module tb_top;
  localparam [31:0] T0 [0:4] = '{32'h0003_8820, 32'h0000_8000, 32'h0001_8020,
                                 32'h0000_8000, 32'h0000_8000};
  localparam [31:0] T1 [0:4] = '{32'h0000_0000, 32'h0000_8001, 32'h0000_8002,
                                 32'h0005_8041, 32'h0021_8041};
  reg         ref_clk, rst_b, ce, hsel, hwrite, slow, fire_alarm, pre_warn, fault_any;
  reg         disable_any;
  reg  [31:0] haddr, hwdata, trig_pin, rd, rnd, seed;
  reg  [1:0]  htrans;
  reg  [99:0] mute;
  wire [31:0] hrdata;
  wire [99:0] ilk_out, fb_pin;
  wire [1:0]  tone;
  wire        hreadyout, hresp, buzzer, ind_summary, ind_disable;
  integer     errors = 0, total_checks = 0, cyc = 0, i, j;

  ilsup_top #(.TICK_CYC(32'h0000_00C8), .BUZ_HALF_CYC(32'h0000_0014)) DUT (
    .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .trig_pin(trig_pin), .fb_pin(fb_pin),
    .fire_alarm(fire_alarm), .pre_warn(pre_warn), .fault_any(fault_any),
    .disable_any(disable_any), .ilk_out(ilk_out), .buzzer(buzzer), .tone(tone),
    .ind_summary(ind_summary), .ind_disable(ind_disable));
  ilsup_equip EQ (.ref_clk(ref_clk), .ilk_out(ilk_out), .mute(mute), .slow(slow),
    .fb_pin(fb_pin));

  // =====================================================================
  // helpers
  function exp_y(input [2:0] f, input [2:0] v);
    case (f)
      3'h0: exp_y = v[0] & v[1] & v[2];
      3'h1: exp_y = v[0] | v[1];
      3'h2: exp_y = v[0] & v[1] | v[2];
      3'h3: exp_y = v[0] | ~v[1] & v[2];
      default: exp_y = v[0] | ~(v[1] & v[2]);
    endcase
  endfunction
  task print_verdict;
    begin
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wait_n(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // address phase held until ready, then data phase held until ready
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1)
        @(posedge ref_clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1)
        @(posedge ref_clk);
      rd = hrdata;
    end
  endtask
  task rdchk(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0000_0000);
      chk(rd & m, e);
    end
  endtask
  // queued commands land within two sweeps; always area 99, point 1
  task cmd(input [2:0] op);
    begin
      bus(1'b1, `ILSUP_CMD, {13'h0000, op, 16'h0163});
      wait_n(350);
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      errors = errors + 1;
      print_verdict;
    end
  end

  // =====================================================================
  // main sequence
  initial begin
    seed = 32'h6a9b_fc09;
    {rst_b, hsel, hwrite, slow, fire_alarm, pre_warn, fault_any, disable_any} = 8'h00;
    {haddr, hwdata, trig_pin, htrans} = 98'h0;
    ce = 1'b1;
    mute = 100'h0;
    wait_n(8);
    rst_b <= 1'b1;
    wait_n(1);
    rdchk(`ILSUP_TIME, 32'hFFFF_FFFF, 32'h0000_0505);
    rdchk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    bus(1'b1, `ILSUP_SEL, 32'h0000_0063);
    bus(1'b1, `ILSUP_CFG, 32'h001B_0164);
    rdchk(`ILSUP_STATUS, 32'h0000_0008, 32'h0000_0008);
    bus(1'b1, `ILSUP_CFG, 32'h001B_0163);
    for (i = 0; i < 5; i = i + 1) begin
      bus(1'b1, `ILSUP_EXPR0, T0[i]);
      bus(1'b1, `ILSUP_EXPR1, T1[i]);
      for (j = 0; j < 8; j = j + 1) begin
        rnd = $random(seed);
        trig_pin <= {rnd[31:3], j[2:0]};
        slow <= rnd[0];
        wait_n(250);
        chk(32'(ilk_out[99]), 32'(exp_y(i[2:0], j[2:0])));
      end
    end
    chk(32'(ind_summary), 32'h0000_0001);
    chk(32'(tone), 32'h0000_0001);
    ce <= 1'b0;
    fire_alarm <= 1'b1;
    wait_n(4);
    chk(32'(tone), 32'h0000_0001);
    ce <= 1'b1;
    wait_n(4);
    chk(32'(tone), 32'h0000_0003);
    {fire_alarm, pre_warn} <= 2'h1;
    wait_n(4);
    chk(32'(tone), 32'h0000_0002);
    {pre_warn, fault_any, disable_any} <= 3'h3;
    wait_n(4);
    chk(32'(tone), 32'h0000_0001);
    chk(32'(ind_summary), 32'h0000_0000);
    {fault_any, disable_any} <= 2'h0;
    cmd(`ILSUP_OP_SIL);
    chk(32'(buzzer), 32'h0000_0000);
    bus(1'b1, `ILSUP_CFG, 32'h001F_0163);
    bus(1'b1, `ILSUP_EXPR0, T0[0]);
    bus(1'b1, `ILSUP_EXPR1, 32'h0000_0000);
    trig_pin <= 32'h0000_0000;
    wait_n(250);
    chk(32'(ilk_out[99]), 32'h0000_0001);
    cmd(`ILSUP_OP_RESET);
    chk(32'(ilk_out[99]), 32'h0000_0000);
    cmd(`ILSUP_OP_ACT);
    chk(32'(ilk_out[99]), 32'h0000_0001);
    chk(32'(tone), 32'h0000_0001);
    cmd(`ILSUP_OP_DIS);
    chk(32'(ilk_out[99]), 32'h0000_0000);
    chk(32'(ind_disable), 32'h0000_0001);
    cmd(`ILSUP_OP_EN);
    chk(32'(ind_disable), 32'h0000_0000);
    cmd(`ILSUP_OP_CDIS);
    cmd(`ILSUP_OP_ACT);
    chk(32'(ilk_out[99]), 32'h0000_0000);
    cmd(`ILSUP_OP_EN);
    chk(32'(ind_disable), 32'h0000_0001);
    cmd(`ILSUP_OP_CEN);
    chk(32'(ind_disable), 32'h0000_0000);
    cmd(`ILSUP_OP_RESET);
    mute <= {1'b1, 99'h0};
    bus(1'b1, `ILSUP_STATUS, 32'h0000_0028);
    trig_pin <= 32'h0000_0007;
    wait_n(650);
    rdchk(`ILSUP_STATUS, 32'h0000_0020, 32'h0000_0000);
    wait_n(1100);
    rdchk(`ILSUP_STATUS, 32'h7F7F_0020, 32'h0163_0020);
    print_verdict;
  end
endmodule
